// >>> hw/bkr_pkg.sv
/*
 * Package for the first step-down regulator control bank: register offsets,
 * field positions, reset values and field encodings.
 * Assumes a byte-wide register port fed by the device's serial host bridge.
 */
package bkr_pkg;
    // Register offsets (byte addresses on the serial register port)
    localparam logic [7:0] ADDR_HRV_ZONE  = 8'h19; // Harvester zone thresholds
    localparam logic [7:0] ADDR_MON_CFG   = 8'h1a; // Monitor multiplexer
    localparam logic [7:0] ADDR_ENABLE    = 8'h1b; // Sequence and enable
    localparam logic [7:0] ADDR_LOOP_CFG  = 8'h1c; // Loop and discharge options
    localparam logic [7:0] ADDR_MODE_CFG  = 8'h1d; // Fast, PWM, adaptive peak
    localparam logic [7:0] ADDR_PEAK      = 8'h1e; // Peak current
    localparam logic [7:0] ADDR_VOLT      = 8'h1f; // Output voltage
    localparam logic [7:0] ADDR_PIN_SEL   = 8'h20; // Control pin select
    localparam logic [7:0] ADDR_SCALE_CFG = 8'h21; // Scaling pin pair
    localparam logic [7:0] ADDR_ALT_V0    = 8'h22; // Alternate voltage 0
    localparam logic [7:0] ADDR_ALT_V1    = 8'h23; // Alternate voltage 1
    localparam logic [7:0] ADDR_ALT_V2    = 8'h24; // Alternate voltage 2
    localparam logic [7:0] ADDR_ALT_V3    = 8'h25; // Alternate voltage 3

    // Writable masks; reserved bits read as zero
    localparam logic [7:0] MASK_HRV_ZONE  = 8'h0f;
    localparam logic [7:0] MASK_MON_CFG   = 8'h7f;
    localparam logic [7:0] MASK_ENABLE    = 8'h03;
    localparam logic [7:0] MASK_MODE_CFG  = 8'h38;
    localparam logic [7:0] MASK_PEAK      = 8'h8f;
    localparam logic [7:0] MASK_VOLT      = 8'h3f;
    localparam logic [7:0] MASK_SCALE_CFG = 8'h1f;

    // Reset values (factory defaults are strap/parameter choices)
    localparam logic [7:0] RST_REG        = 8'h00;
    localparam logic [7:0] RST_HRV_ZONE   = 8'h0f;

    // Field positions
    localparam int MON_RATIO_LSB  = 5;
    localparam int MON_HIGHZ_BIT  = 4;
    localparam int SEQ_LSB        = 5;
    localparam int LOOP_INTEG_BIT = 7;
    localparam int LOOP_POWER_GOOD_BIT = 6;
    localparam int LOOP_FAST_BIT  = 5;
    localparam int LOOP_PSV_BIT   = 4;
    localparam int LOOP_ACT_BIT   = 3;
    localparam int LOOP_EMI_BIT   = 2;
    localparam int LOOP_HALF_BIT  = 1;
    localparam int LOOP_LX_BIT    = 0;
    localparam int MODE_PIN2_BIT  = 5;
    localparam int MODE_PWM_BIT   = 4;
    localparam int MODE_ADPT_BIT  = 3;
    localparam int PEAK_BYP_BIT   = 7;
    localparam int FAST_PIN       = 2;

    // Boot sequence codes
    typedef enum logic [2:0] {
        SEQ_OFF  = 3'b000,
        SEQ_AT0  = 3'b010,
        SEQ_AT25 = 3'b011,
        SEQ_AT50 = 3'b100,
        SEQ_SW   = 3'b111
    } bkr_seq_t;

    // Enable select codes
    localparam logic [1:0] EN_OFF  = 2'h0;
    localparam logic [1:0] EN_ON   = 2'h1;
    localparam logic [1:0] EN_PINS = 2'h2;

    // Monitor channel and scaling limits
    localparam logic [3:0] MON_CH_OFF  = 4'h0;
    localparam logic [3:0] MON_CH_LAST = 4'h9;
    localparam logic [4:0] DVS_OFF     = 5'h00;
    localparam logic [4:0] DVS_LAST    = 5'h1c;
    localparam logic [4:0] DVS_SPI     = 5'h1d;

    // Boot progress points, in percent of the boot delay
    localparam logic [6:0] BOOT_PCT_25  = 7'd25;
    localparam logic [6:0] BOOT_PCT_50  = 7'd50;
    localparam logic [6:0] BOOT_PCT_100 = 7'd100;
endpackage : bkr_pkg

// >>> hw/bkr_pair_decode.sv
/*
 * Decodes the scaling pin pair code into the two control pin numbers.
 * Assumes codes 1..28 walk pairs (0/1,0/2..0/7,1/2,..,6/7) in order.
 */
`timescale 1ns/1ps
module bkr_pair_decode
    import bkr_pkg::*;
(
    input  wire logic [4:0] code,
    output logic            valid,
    output logic [2:0]      pin_lo,
    output logic [2:0]      pin_hi
);
    // Walk the pair table; small enough that a loop beats a big case
    always_comb begin
        logic [4:0] idx;
        idx    = 5'h01;
        valid  = 1'b0;
        pin_lo = 3'h0;
        pin_hi = 3'h0;
        for (int a = 0; a < 7; a++) begin
            for (int b = a + 1; b < 8; b++) begin
                if (idx == code) begin
                    valid  = 1'b1;
                    pin_lo = 3'(a);
                    pin_hi = 3'(b);
                end
                idx = idx + 5'h01;
            end
        end
    end
endmodule : bkr_pair_decode

// >>> hw/bkr_mon_decode.sv
/*
 * Decodes the monitor channel selector into a one-hot analog switch select.
 * Assumes the analog mux closes at most one switch per set bit.
 */
`timescale 1ns/1ps
module bkr_mon_decode
    import bkr_pkg::*;
(
    input  wire logic [3:0] channel,
    output logic [8:0]      onehot,
    output logic            off
);
    // Channel 1 is charge current, 2..9 battery through safe output
    always_comb begin
        onehot = 9'h000;
        off    = 1'b1;
        if (channel != MON_CH_OFF && channel <= MON_CH_LAST) begin
            onehot = 9'h001 << (channel - 4'h1);
            off    = 1'b0;
        end
    end
endmodule : bkr_mon_decode

// >>> hw/bkr_regs.sv
/*
 * First step-down regulator control bank: enable sequencing, pin-controlled
 * enable, loop options, peak and voltage codes, dynamic voltage scaling,
 * analog monitor mux select and harvester zone thresholds.
 * Assumes a byte register port from the serial host bridge, synchronous
 * control pins, and a boot sequencer giving progress in percent.
 */
//
// Contract
// R1: Ratio field picks monitor divider 1:1..4:1
// R2: Off-state bit matters only when channel zero; code also applies it to reserved channel codes above 9
// R3: Channel selector decodes; reserved codes disable
// R4: Read-only sequence code sets boot enable point
// R5: Enable field acts only under sequence 111
// R6: Enable code 00 gives no active discharge
// R7: Pin mode enable is OR of selected pins
// R8: Bit 7 disables integrator, proportional only
// R9: Bit 6 keeps power-good during transitions
// R10: Bit 5 selects pretrigger fast mode
// R11: Bits 4,3 discharge also when enable low
// R12: Bit 2 selects slow-edge mode
// R13: Bit 1 halves power switch size
// R14: Bit 0 selects freewheel entry condition
// R15: Mode bit 5 lets pin 2 force fast
// R16: Mode bit 4 forces PWM switching
// R17: Mode bit 3 fixes peak at code
// R18: Peak bit 7 bypasses lookup table
// R19: Six-bit voltage code passed linear
// R20: Scaling code picks pin pair, SPI, off
// R21: Pin states 00,01 pick alternates zero, one
// R22: Pin states 10,11 pick alternates two, three
// R23: Harvester zone fields give threshold reduction
// R24: Lower pin drives index least significant bit
// R25: Reserved codes act disabled; reserved bits zero
`timescale 1ns/1ps
module bkr_regs
    import bkr_pkg::*;
#(
    parameter logic [2:0] SEQ_STRAP = 3'b111 // Factory sequence code
)(
    input  wire logic       CLOCK,
    input  wire logic       RST,
    input  wire logic [7:0] ADDR,
    input  wire logic [7:0] WDATA,
    input  wire logic       WR,
    input  wire logic       RD,
    output logic [7:0]      RDATA,
    output logic            RVALID,
    input  wire logic [7:0] CONTROL_PIN,
    input  wire logic [6:0] BOOT_PERCENT,
    input  wire logic       HARD_RESET,
    output logic            REG_ENABLE,
    output logic            ACTIVE_DISCHARGE,
    output logic            PASSIVE_DISCHARGE,
    output logic            INTEGRATOR_DISABLE,
    output logic            POWER_GOOD_DURING_TRANSITION,
    output logic            PRETRIGGER_FAST_MODE,
    output logic            SLOW_EDGE_MODE,
    output logic            SWITCH_HALF_SIZE,
    output logic            FREEWHEEL_ENTRY_SELECT,
    output logic            FORCED_PWM,
    output logic            ADAPTIVE_PEAK_DISABLE,
    output logic            PEAK_TABLE_BYPASS,
    output logic [3:0]      PEAK_CURRENT_CODE,
    output logic [5:0]      OUTPUT_VOLTAGE_CODE,
    output logic            SCALING_SPI_MODE,
    output logic [1:0]      MONITOR_DIVIDER_RATIO,
    output logic [8:0]      MONITOR_CHANNEL_ONEHOT,
    output logic            MONITOR_PULLDOWN,
    output logic [1:0]      HARVEST_ROOM_REDUCTION,
    output logic [1:0]      HARVEST_COOL_REDUCTION
);
    // All state in one record
    typedef struct packed {
        logic [7:0]  hrv_zone;     // Room [3:2], cool [1:0]
        logic [7:0]  mon_cfg;      // Ratio, off-state, channel
        logic [2:0]  seq;          // Caught strap, read-only
        logic        seq_loaded;   // Strap captured after reset
        logic [1:0]  en_sel;       // Enable select field
        logic [7:0]  loop_cfg;     // Loop and discharge bits
        logic [7:0]  mode_cfg;     // Fast, PWM, adaptive
        logic [7:0]  peak;         // Bypass and code
        logic [7:0]  volt;         // Main voltage code
        logic [7:0]  pin_sel;      // Control pin select
        logic [7:0]  scale_cfg;    // Pin pair code
        logic [3:0][5:0] alt_v;    // Alternate voltages, packed to keep the record packed
        logic [7:0]  rdata;        // Read data
        logic        rvalid;       // Read strobe
        logic        enable;       // Regulator enable
        logic        act_dsc;      // Active discharge
        logic        psv_dsc;      // Passive discharge
        logic        fast;         // Effective fast mode
        logic [5:0]  vcode;        // Effective voltage code
        logic        spi;          // Scaling in SPI mode
        logic [8:0]  mon_onehot;   // Monitor switch select
        logic        mon_pd;       // Monitor pull-down
    } bkr_state_t;

    bkr_state_t st;        // Registered state
    bkr_state_t next_st;   // Next state

    logic       pair_valid;  // Scaling code names a pair
    logic [2:0] pair_lo;     // Lower pin of pair
    logic [2:0] pair_hi;     // Higher pin of pair
    logic [8:0] mon_onehot;  // Decoded monitor channel
    logic       mon_off;     // Monitor disabled

    // Pair table decoder
    bkr_pair_decode u_pair (
        .code   (st.scale_cfg[4:0]),
        .valid  (pair_valid),
        .pin_lo (pair_lo),
        .pin_hi (pair_hi)
    );

    // Monitor channel decoder
    bkr_mon_decode u_mon (
        .channel (st.mon_cfg[3:0]),
        .onehot  (mon_onehot),
        .off     (mon_off)
    );

    // Reads the register at an address; reserved bits held zero on write
    function automatic logic [7:0] read_reg(input bkr_state_t s, input logic [7:0] a);
        logic [7:0] d;
        d = 8'h00;
        if (a == ADDR_HRV_ZONE) begin
            d = s.hrv_zone;
        end else if (a == ADDR_MON_CFG) begin
            d = s.mon_cfg;
        end else if (a == ADDR_ENABLE) begin
            d = {s.seq, 3'b000, s.en_sel};
        end else if (a == ADDR_LOOP_CFG) begin
            d = s.loop_cfg;
        end else if (a == ADDR_MODE_CFG) begin
            d = s.mode_cfg;
        end else if (a == ADDR_PEAK) begin
            d = s.peak;
        end else if (a == ADDR_VOLT) begin
            d = s.volt;
        end else if (a == ADDR_PIN_SEL) begin
            d = s.pin_sel;
        end else if (a == ADDR_SCALE_CFG) begin
            d = s.scale_cfg;
        end else if (a >= ADDR_ALT_V0 && a <= ADDR_ALT_V3) begin
            d = {2'b00, s.alt_v[2'(a - ADDR_ALT_V0)]};
        end
        return d;
    endfunction : read_reg

    // Register writes, read port and derived regulator controls
    always_comb begin
        logic       sw_on;
        logic       seq_on;
        logic [1:0] idx;
        seq_on         = 1'b0;
        sw_on          = 1'b0;
        idx            = 2'b00;
        next_st        = st;
        next_st.rvalid = 1'b0;
        // Strap caught the first cycle after reset, never under reset
        if (!st.seq_loaded) begin
            next_st.seq        = SEQ_STRAP;
            next_st.seq_loaded = 1'b1;
        end
        // Byte writes; unmapped addresses are ignored
        if (WR) begin
            if (ADDR == ADDR_HRV_ZONE) begin
                next_st.hrv_zone = WDATA & MASK_HRV_ZONE;        // R23
            end else if (ADDR == ADDR_MON_CFG) begin
                next_st.mon_cfg = WDATA & MASK_MON_CFG;          // R25
            end else if (ADDR == ADDR_ENABLE) begin
                next_st.en_sel = WDATA[1:0];                     // R4
            end else if (ADDR == ADDR_LOOP_CFG) begin
                next_st.loop_cfg = WDATA;
            end else if (ADDR == ADDR_MODE_CFG) begin
                next_st.mode_cfg = WDATA & MASK_MODE_CFG;
            end else if (ADDR == ADDR_PEAK) begin
                next_st.peak = WDATA & MASK_PEAK;
            end else if (ADDR == ADDR_VOLT) begin
                next_st.volt = WDATA & MASK_VOLT;
            end else if (ADDR == ADDR_PIN_SEL) begin
                next_st.pin_sel = WDATA;
            end else if (ADDR == ADDR_SCALE_CFG) begin
                next_st.scale_cfg = WDATA & MASK_SCALE_CFG;
            end else if (ADDR >= ADDR_ALT_V0 && ADDR <= ADDR_ALT_V3) begin
                next_st.alt_v[2'(ADDR - ADDR_ALT_V0)] = WDATA[5:0];
            end
        end
        // Read answers one cycle later; unmapped reads return zero
        if (RD) begin
            next_st.rdata  = read_reg(st, ADDR);
            next_st.rvalid = 1'b1;
        end
        // Boot sequence points; reserved sequence codes keep it off
        case (st.seq)
            SEQ_AT0:  seq_on = 1'b1;                              // R4
            SEQ_AT25: seq_on = (BOOT_PERCENT >= BOOT_PCT_25);     // R4
            SEQ_AT50: seq_on = (BOOT_PERCENT >= BOOT_PCT_50);     // R4
            SEQ_SW: begin
                // Enable field takes over after the full boot delay
                if (BOOT_PERCENT >= BOOT_PCT_100) begin
                    case (st.en_sel)
                        EN_ON:   sw_on = 1'b1;                         // R5
                        EN_PINS: sw_on = |(st.pin_sel & CONTROL_PIN);  // R7
                        default: sw_on = 1'b0;                         // R25
                    endcase
                end
            end
            default:  seq_on = 1'b0;                              // R25
        endcase
        next_st.enable = (seq_on | sw_on) & st.seq_loaded;
        // Discharge: hard reset always, enable low only if bit selected;
        // enable code 00 alone never discharges actively
        next_st.act_dsc = HARD_RESET |
                          (st.loop_cfg[LOOP_ACT_BIT] & ~next_st.enable); // R6 R11
        next_st.psv_dsc = HARD_RESET |
                          (st.loop_cfg[LOOP_PSV_BIT] & ~next_st.enable); // R11
        // Fast mode from the bit or from pin 2 when allowed
        next_st.fast = st.loop_cfg[LOOP_FAST_BIT] |
                       (st.mode_cfg[MODE_PIN2_BIT] & CONTROL_PIN[FAST_PIN]); // R10 R15
        // Voltage: main code unless a valid pin pair is chosen
        idx = {CONTROL_PIN[pair_hi], CONTROL_PIN[pair_lo]};      // R24
        next_st.spi = (st.scale_cfg[4:0] == DVS_SPI);            // R20
        if (pair_valid && st.scale_cfg[4:0] <= DVS_LAST) begin
            next_st.vcode = st.alt_v[idx];                       // R21 R22
        end else begin
            // Off, SPI readback not held here, reserved all use main code
            next_st.vcode = st.volt[5:0];                        // R19 R20
        end
        // Monitor: off-state bit counts when channel zero or a reserved code above 9
        next_st.mon_onehot = mon_onehot;                         // R3
        next_st.mon_pd     = mon_off & ~st.mon_cfg[MON_HIGHZ_BIT]; // R2
    end

    // State register
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            st            <= '0;
            st.hrv_zone   <= RST_HRV_ZONE;
            st.mon_cfg    <= RST_REG;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from state flops
    assign RDATA                        = st.rdata;
    assign RVALID                       = st.rvalid;
    assign REG_ENABLE                   = st.enable;
    assign ACTIVE_DISCHARGE             = st.act_dsc;
    assign PASSIVE_DISCHARGE            = st.psv_dsc;
    assign INTEGRATOR_DISABLE           = st.loop_cfg[LOOP_INTEG_BIT]; // R8
    assign POWER_GOOD_DURING_TRANSITION = st.loop_cfg[LOOP_POWER_GOOD_BIT]; // R9
    assign PRETRIGGER_FAST_MODE         = st.fast;
    assign SLOW_EDGE_MODE               = st.loop_cfg[LOOP_EMI_BIT];   // R12
    assign SWITCH_HALF_SIZE             = st.loop_cfg[LOOP_HALF_BIT];  // R13
    assign FREEWHEEL_ENTRY_SELECT       = st.loop_cfg[LOOP_LX_BIT];    // R14
    assign FORCED_PWM                   = st.mode_cfg[MODE_PWM_BIT];   // R16
    assign ADAPTIVE_PEAK_DISABLE        = st.mode_cfg[MODE_ADPT_BIT];  // R17
    assign PEAK_TABLE_BYPASS            = st.peak[PEAK_BYP_BIT];       // R18
    assign PEAK_CURRENT_CODE            = st.peak[3:0];                // R18
    assign OUTPUT_VOLTAGE_CODE          = st.vcode;
    assign SCALING_SPI_MODE             = st.spi;
    assign MONITOR_DIVIDER_RATIO        = st.mon_cfg[MON_RATIO_LSB +: 2]; // R1
    assign MONITOR_CHANNEL_ONEHOT       = st.mon_onehot;
    assign MONITOR_PULLDOWN             = st.mon_pd;
    assign HARVEST_ROOM_REDUCTION       = st.hrv_zone[3:2];            // R23
    assign HARVEST_COOL_REDUCTION       = st.hrv_zone[1:0];            // R23
endmodule : bkr_regs

// >>> verif/bkr_host_model.sv
/*
 * Far-side model: host byte port behind the serial bridge, and the
 * eight external control pins.
 * Assumes the bench calls its tasks; everything moves on falling edges.
 */
`timescale 1ns/1ps
module bkr_host_model (
    input  wire logic       clock,
    input  wire logic [7:0] rdata,
    input  wire logic       rvalid,
    output logic [7:0]      addr,
    output logic [7:0]      wdata,
    output logic            wr,
    output logic            rd,
    output logic [7:0]      pins
);
    // Idle port, all pins low
    initial begin
        addr  = 8'h00;
        wdata = 8'h00;
        wr    = 1'b0;
        rd    = 1'b0;
        pins  = 8'h00;
    end

    // One write, strobe held over exactly one sampling edge
    task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        addr  = a;
        wdata = d;
        wr    = 1'b1;
        @(negedge clock);
        wr    = 1'b0;
        // Released lines flip so a stale value never passes for a live one
        addr  = ~a;
        wdata = ~d;
    endtask : wr_byte

    // One read; the answer stands for one cycle, so take it at once
    task automatic rd_byte(input logic [7:0] a, output logic [7:0] d, output logic ok);
        @(negedge clock);
        addr = a;
        rd   = 1'b1;
        @(negedge clock);
        rd   = 1'b0;
        addr = ~a;
        ok   = rvalid;
        d    = rdata;
    endtask : rd_byte

    // New pin levels, changed away from the sampling edge
    task automatic set_pins(input logic [7:0] p);
        @(negedge clock);
        pins = p;
    endtask : set_pins
endmodule : bkr_host_model

// >>> verif/bkr_regs_chk.sv
/*
 * Port checker for the regulator control bank.
 * Assumes one clock and the asynchronous active-high reset; bound below.
 */
`timescale 1ns/1ps
module bkr_regs_chk
    import bkr_pkg::*;
#(
    parameter logic [2:0] SEQ_STRAP = 3'b111
)(
    input wire logic       CLOCK,
    input wire logic       RST,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic       WR,
    input wire logic       RD,
    input wire logic [7:0] RDATA,
    input wire logic       RVALID,
    input wire logic [6:0] BOOT_PERCENT,
    input wire logic       HARD_RESET,
    input wire logic       REG_ENABLE,
    input wire logic       ACTIVE_DISCHARGE,
    input wire logic       PASSIVE_DISCHARGE,
    input wire logic [1:0] MONITOR_DIVIDER_RATIO,
    input wire logic [8:0] MONITOR_CHANNEL_ONEHOT,
    input wire logic       MONITOR_PULLDOWN,
    input wire logic       SCALING_SPI_MODE
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);

    // Read answer one edge later, and read data held between answers
    property p_ans; RD |=> RVALID; endproperty
    a_ans: assert property (p_ans) else $error("read not answered");
    property p_hold; !RVALID |-> $stable(RDATA); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    // Ratio follows the last monitor write once settled
    property p_ratio; (WR && ADDR == ADDR_MON_CFG) ##1 !(WR && ADDR == ADDR_MON_CFG)
        |=> MONITOR_DIVIDER_RATIO == $past(WDATA[6:5], 2); endproperty
    a_ratio: assert property (p_ratio) else $error("ratio wrong");
    property p_pull; MONITOR_PULLDOWN |-> MONITOR_CHANNEL_ONEHOT == 9'h000; endproperty
    a_pull: assert property (p_pull) else $error("pulldown with channel");
    property p_oh; $onehot0(MONITOR_CHANNEL_ONEHOT); endproperty
    a_oh: assert property (p_oh) else $error("two channels closed");
    // Sequence field is the strap and spare bits read zero
    property p_seq; RVALID && $past(ADDR) == ADDR_ENABLE
        |-> RDATA[7:2] == {SEQ_STRAP, 3'b000}; endproperty
    a_seq: assert property (p_seq) else $error("sequence readback");
    property p_boot; (SEQ_STRAP == 3'b111 && BOOT_PERCENT < BOOT_PCT_100) [*2]
        |=> !REG_ENABLE; endproperty
    a_boot: assert property (p_boot) else $error("enabled before boot end");
    property p_hrst; HARD_RESET |-> ##[1:2] ACTIVE_DISCHARGE && PASSIVE_DISCHARGE; endproperty
    a_hrst: assert property (p_hrst) else $error("no discharge in hard reset");
    // Running regulator is never discharged outside hard reset
    property p_run; REG_ENABLE && $past(REG_ENABLE) && !HARD_RESET && !$past(HARD_RESET)
        |-> !ACTIVE_DISCHARGE && !PASSIVE_DISCHARGE; endproperty
    a_run: assert property (p_run) else $error("discharge while enabled");
    property p_unmap; RVALID && !($past(ADDR) inside {[ADDR_HRV_ZONE:ADDR_ALT_V3]})
        |-> RDATA == 8'h00; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");

    c_read: cover property (RVALID);
    c_en: cover property ($rose(REG_ENABLE));
    c_spi: cover property (SCALING_SPI_MODE);
endmodule : bkr_regs_chk

bind bkr_regs bkr_regs_chk #(.SEQ_STRAP(SEQ_STRAP)) u_chk (.CLOCK, .RST, .ADDR, .WDATA,
    .WR, .RD, .RDATA, .RVALID, .BOOT_PERCENT, .HARD_RESET, .REG_ENABLE, .ACTIVE_DISCHARGE,
    .PASSIVE_DISCHARGE, .MONITOR_DIVIDER_RATIO, .MONITOR_CHANNEL_ONEHOT, .MONITOR_PULLDOWN,
    .SCALING_SPI_MODE);

// >>> verif/testbench.sv
/*
 * Bench for the regulator control bank: register table, enable, discharge,
 * pin select, fast pin, voltage scaling and monitor decode.
 * Assumes the host model drives the byte port and pins on falling edges.
 */
`timescale 1ns/1ps
module testbench;
    import bkr_pkg::*;
    typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] r;} bkr_row_t;
    // Address, write data, read-back value
    localparam bkr_row_t ROWS [14] = '{
        '{8'h19, 8'h06, 8'h06}, '{8'h1a, 8'hd4, 8'h54}, '{8'h1b, 8'hff, 8'he3},
        '{8'h1c, 8'ha5, 8'ha5}, '{8'h1d, 8'hf7, 8'h30}, '{8'h1e, 8'h7a, 8'h0a},
        '{8'h1f, 8'h7f, 8'h3f}, '{8'h20, 8'h5a, 8'h5a}, '{8'h21, 8'hff, 8'h1f},
        '{8'h22, 8'hc1, 8'h01}, '{8'h23, 8'hc2, 8'h02}, '{8'h24, 8'hc3, 8'h03},
        '{8'h25, 8'hc4, 8'h04}, '{8'h31, 8'hff, 8'h00}};
    logic       clock, rst, wr, rd, rvalid, hard_reset, en, act, psv, ok;
    logic       integ, power_good, fast, slow, half, lxsel, fpwm, adpt, byp, spi, pull;
    logic [7:0] addr, wdata, rdata, pins, v;
    logic [6:0] boot;
    logic [5:0] vcode;
    logic [3:0] peak;
    logic [1:0] ratio, room, cool;
    logic [8:0] onehot, exp_oh;
    int         fails = 0, num_checks = 0, cycles = 0;

    bkr_regs #(.SEQ_STRAP(3'b111)) u_dut (.CLOCK(clock), .RST(rst), .ADDR(addr),
        .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .RVALID(rvalid), .CONTROL_PIN(pins),
        .BOOT_PERCENT(boot), .HARD_RESET(hard_reset), .REG_ENABLE(en),
        .ACTIVE_DISCHARGE(act), .PASSIVE_DISCHARGE(psv), .INTEGRATOR_DISABLE(integ),
        .POWER_GOOD_DURING_TRANSITION(power_good), .PRETRIGGER_FAST_MODE(fast),
        .SLOW_EDGE_MODE(slow), .SWITCH_HALF_SIZE(half), .FREEWHEEL_ENTRY_SELECT(lxsel),
        .FORCED_PWM(fpwm), .ADAPTIVE_PEAK_DISABLE(adpt), .PEAK_TABLE_BYPASS(byp),
        .PEAK_CURRENT_CODE(peak), .OUTPUT_VOLTAGE_CODE(vcode), .SCALING_SPI_MODE(spi),
        .MONITOR_DIVIDER_RATIO(ratio), .MONITOR_CHANNEL_ONEHOT(onehot),
        .MONITOR_PULLDOWN(pull), .HARVEST_ROOM_REDUCTION(room), .HARVEST_COOL_REDUCTION(cool));
    bkr_host_model u_host (.clock(clock), .rdata(rdata), .rvalid(rvalid), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .pins(pins));

    // 100 MHz clock
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // Hang guard: the sequence needs well under a thousand cycles
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fails++;
            report_and_stop();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        u_host.rd_byte(a, d, ok);
        check(ok, 1'b1);
        check(d, exp);
    endtask : rd_chk
    // Writes and pin moves wait three cycles, past the two-edge output lag
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        u_host.wr_byte(a, d);
        repeat (3) @(negedge clock);
    endtask : put
    task automatic pin(input logic [7:0] p);
        u_host.set_pins(p);
        repeat (3) @(negedge clock);
    endtask : pin
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop

    initial begin
        rst = 1'b1;
        boot = 7'h00;
        hard_reset = 1'b0;
        repeat (12) @(negedge clock);
        rst = 1'b0;
        // Reset values of the whole table
        for (int a = 8'h19; a <= 8'h25; a++)
            rd_chk(8'(a), a == 8'h19 ? RST_HRV_ZONE : a == 8'h1b ? 8'he0 : RST_REG);
        boot = BOOT_PCT_100;
        foreach (ROWS[i]) begin
            put(ROWS[i].a, ROWS[i].d);
            rd_chk(ROWS[i].a, ROWS[i].r);
        end
        check({room, cool}, 4'h6);
        check({ratio, onehot, pull}, {2'h2, 9'h008, 1'b0});
        check({integ, power_good, fast, slow, half, lxsel}, 6'h2d);
        check({fpwm, adpt, byp, peak}, 7'h4a);
        check({en, spi, vcode}, 8'h3f);
        put(8'h1c, 8'h5a);
        check({integ, power_good, fast, slow, half, lxsel}, 6'h12);
        // Enable, boot gate and discharge
        put(8'h1b, 8'h01);
        check({en, act, psv}, 3'h4);
        boot = BOOT_PCT_100 - 7'h01;
        repeat (3) @(negedge clock);
        check({en, act, psv}, 3'h3);
        boot = BOOT_PCT_100;
        put(8'h1b, 8'h00);
        check({en, act, psv}, 3'h3);
        put(8'h1c, 8'h00);
        check({en, act, psv}, 3'h0);
        hard_reset = 1'b1;
        repeat (3) @(negedge clock);
        check({act, psv}, 2'h3);
        hard_reset = 1'b0;
        // Pin-controlled enable, select mask from the table row
        put(8'h1b, 8'h02);
        for (int i = 0; i < 8; i++) begin
            pin(8'h01 << i);
            check(en, ROWS[7].d[i]);
        end
        pin(8'h00);
        check(en, 1'b0);
        pin(8'hff);
        check(en, 1'b1);
        pin(8'h04);
        check(fast, 1'b1);
        put(8'h1d, 8'h10);
        check({fast, fpwm}, 2'h1);
        // Scaling on the top pair walks all four alternates
        put(8'h1f, 8'h12);
        put(8'h21, 8'h1c);
        for (int i = 0; i < 4; i++) begin
            pin({2'(i), 6'h00});
            check(vcode, 6'(i + 1));
        end
        put(8'h21, 8'h01);
        pin(8'h01);
        check(vcode, 6'h02);
        put(8'h21, 8'h1d);
        check({spi, vcode}, 7'h52);
        put(8'h21, 8'h00);
        check({spi, vcode}, 7'h12);
        // Every channel code, plus channel zero in high impedance
        for (int i = 0; i < 17; i++) begin
            v = {1'b0, 2'(i), i[4], i[3:0]};
            put(8'h1a, v);
            exp_oh = (v[3:0] >= 4'h1 && v[3:0] <= 4'h9) ? 9'h001 << (v[3:0] - 4'h1) : 9'h000;
            check({ratio, onehot, pull}, {v[6:5], exp_oh, exp_oh == 9'h000 && !v[4]});
        end
        report_and_stop();
    end
endmodule : testbench
